// ==== lcs_pack_model.sv ====
// battery pack, thermistor and timer model driving the comparator levels
`default_nettype none
module lcs_pack_model
  import lcs_pkg::*;
#(
  parameter int TICK_CYCLES = 4 // clocks per charge timer tick
) (
  input wire logic clk_i, // clock
  input wire lcs_sense_type cmd_i, // pack condition from bench
  output var lcs_sense_type sense_o // comparator levels
);
  int tick_cnt = 0; // tick divider
  lcs_sense_type nxt; // levels for the next edge
  initial sense_o = '0;
  // levels move just after the edge; tick is a free square wave
  always @(posedge clk_i) begin
    nxt = cmd_i;
    nxt.timer_tick = (tick_cnt < TICK_CYCLES / 2);
    tick_cnt <= (tick_cnt + 1) % TICK_CYCLES;
    sense_o <= nxt;
  end
endmodule
`default_nettype wire

// ==== lcs_pkg.sv ====
// package: constants, types and register map of the charge sequencer
`default_nettype none
package lcs_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 32'h0000_0064;
  localparam int MS_NS = 32'h000F_4240;
  localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  // qualification times in ms
  localparam logic [3:0] EOC_FILTER_MS = 4'h5;
  localparam logic [3:0] RCH_FILTER_MS = 4'h4;
  // blink: serration period and slow phase
  localparam int SERR_PERIOD_NS = 32'h0000_4E20;
  localparam logic [7:0] SERR_CYCLES = 8'(SERR_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [7:0] SERR_HI_DUTY = 8'h96;
  localparam logic [7:0] SERR_LO_DUTY = 8'h32;
  localparam logic [8:0] BLINK_HALF_MS = 9'h14D;
  // register map, byte addresses
  localparam logic [7:0] REG_TIMEOUT = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam logic [23:0] TIMEOUT_RESET = 24'h00_0E10;
  // status register field positions
  localparam int ST_STATE_LSB = 32'h0000_0000;
  localparam int ST_EOC_BIT = 32'h0000_0004;
  localparam int ST_TEMP_BIT = 32'h0000_0005;
  localparam int ST_RCH_BIT = 32'h0000_0006;
  localparam int ST_SHORT_BIT = 32'h0000_0007;
  // sequencer states
  typedef enum logic [2:0] {
    ST_OFF, ST_TRICKLE, ST_FAST, ST_DONE, ST_FAULT
  } lcs_state_type;
  // qualified comparator and strap inputs
  typedef struct packed {
    logic supply_lockout_ok;   // supply above lockout
    logic vin_above_bat;       // supply exceeds battery by margin
    logic vin_below_bat;       // supply under battery
    logic trickle_low;         // battery under trickle threshold
    logic recharge_low;        // battery under recharge threshold
    logic end_current_low;     // current under end threshold
    logic near_float;          // battery near float
    logic thermistor_hot;      // hot indication
    logic thermistor_cold;     // cold indication
    logic thermistor_off;      // thermistor input grounded
    logic short_bat;           // shorted battery detected
    logic enable_n;            // charger enable, active low
    logic timer_tied_end_current_threshold_in;     // timer strap: timer disabled
    logic timer_grounded;      // timer strap: current end
    logic timer_tick;          // charge timer tick
  } lcs_sense_type;
endpackage
`default_nettype wire

// ==== lcs_sequencer.sv ====
// charge cycle sequencer with wishbone register slave
//
// Decided for this implementation: the register offsets and register access over Wishbone.
`default_nettype none
module lcs_sequencer
  import lcs_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF // cycles per ms tick
) (
  input wire logic clk_i,                 // 10 MHz clock
  input wire logic rst_i,                 // sync reset, high
  input wire lcs_sense_type sense_i,      // comparator inputs
  input wire logic wb_cyc_i,              // bus cycle
  input wire logic wb_stb_i,              // bus strobe
  input wire logic wb_we_i,               // bus write
  input wire logic [7:0] wb_adr_i,        // byte address
  input wire logic [3:0] wb_sel_i,        // byte enables
  input wire logic [31:0] wb_dat_i,       // write data
  output logic [31:0] wb_dat_o,           // read data
  output logic wb_ack_o,                  // bus acknowledge
  output logic trickle_en_o,              // linear charger on
  output logic fast_en_o,                 // switching charger on
  output logic charge_status_strong_o,    // strong pull-down on
  output logic charge_status_weak_o,      // weak current sink on
  output logic fault_o,                   // battery fault high
  output logic divider_en_o               // sense divider connected
);

  // synchroniser stages
  logic [$bits(lcs_sense_type)-1:0] sync1;
  logic [$bits(lcs_sense_type)-1:0] sync2;
  // qualified inputs
  lcs_sense_type s;
  // delayed tick for edge detect
  logic tick_d;
  // one clock per charge timer tick
  logic timer_step;
  // ms prescaler
  logic [15:0] ms_cnt;
  // one clock per ms
  logic ms_tick;
  // sequencer state
  lcs_state_type state;
  // cycle is a recharge
  logic recharge;
  // charge timer count
  logic [23:0] chg_cnt;
  // full charge time, software set
  logic [23:0] timeout;
  // end of charge filter count
  logic [3:0] eoc_ms;
  // latched end of charge
  logic eoc;
  // recharge filter count
  logic [3:0] rch_ms;
  // recharge qualified
  logic rch_qual;
  // serration counter
  logic [7:0] serr_cnt;
  // slow blink phase counter
  logic [8:0] blink_ms;
  // slow blink phase
  logic blink_phase;
  // derived conditions
  // thermistor out of window with monitor on
  logic temp_fault;
  // power and enable allow a fresh cycle
  logic start_ok;
  // power and enable allow the cycle to go on
  logic keep_ok;
  // capacitor strap: charge timer counts
  logic timer_on;
  // a charger is selected
  logic charging;
  // time limit of this cycle
  logic [23:0] limit;
  // charge time used up
  logic expired;
  // low battery held beyond a quarter
  logic trickle_over;
  // serration pulse of the blink
  logic blink_on;
  // low supply or reverse supply
  logic sleep;
  // bus decode
  // request not yet answered
  logic bus_req;
  // write request
  logic bus_wr;
  // word aligned address
  logic [7:0] bus_adr;
  // read value before the output register
  logic [31:0] rdata;

  // two flip-flop synchroniser on every input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= sense_i;
      sync2 <= sync1;
    end
  end

  // struct view of the second stage only
  assign s = lcs_sense_type'(sync2);

  // tick edge detector on the synchronised tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_d <= 1'b0;
    end else begin
      tick_d <= s.timer_tick;
    end
  end

  assign timer_step = s.timer_tick & ~tick_d;

  // millisecond prescaler from the clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ms_cnt <= '0;
    end else if (ms_tick) begin
      ms_cnt <= '0;
    end else begin
      ms_cnt <= ms_cnt + 16'h0001;
    end
  end

  assign ms_tick = (ms_cnt == 16'(MS_CYCLES - 1));

  // thermistor fault only with monitor enabled
  assign temp_fault = ~s.thermistor_off &
    (s.thermistor_hot | s.thermistor_cold);
  // start and keep conditions for a cycle
  assign start_ok = s.supply_lockout_ok & s.vin_above_bat &
    ~s.enable_n;
  assign keep_ok = s.supply_lockout_ok &
    ~s.vin_below_bat & ~s.enable_n;
  // only the capacitor strap runs the timer
  assign timer_on = ~s.timer_tied_end_current_threshold_in & ~s.timer_grounded;
  assign charging = (state == ST_TRICKLE) | (state == ST_FAST);
  // recharge gets half the programmed time
  assign limit = recharge ? (timeout >> 1) : timeout;
  assign expired = timer_on & (chg_cnt >= limit);
  assign trickle_over = timer_on & (chg_cnt > (timeout >> 2));
  assign sleep = ~s.supply_lockout_ok | s.vin_below_bat;

  // main charge cycle sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_OFF;
      recharge <= 1'b0;
    end else if (state == ST_OFF) begin
      // fresh cycle once power and enable allow
      if (start_ok) begin
        state <= s.trickle_low ? ST_TRICKLE : ST_FAST;
        recharge <= 1'b0;
      end
    end else if (!keep_ok) begin
      // lockout, reverse supply or disable
      state <= ST_OFF;
    end else begin
      case (state)
        ST_TRICKLE: begin
          // temperature hold keeps the state and stops the charge timer
          if (temp_fault) begin
            state <= ST_TRICKLE;
          end else if (trickle_over) begin
            state <= ST_FAULT;
          end else if (!s.trickle_low) begin
            state <= ST_FAST;
          end
        end
        ST_FAST: begin
          if (temp_fault) begin
            state <= ST_FAST;
          end else if (expired) begin
            state <= ST_DONE;
          end else if (s.timer_grounded && eoc) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          // qualified sag starts a recharge cycle
          if (rch_qual) begin
            state <= s.trickle_low ? ST_TRICKLE : ST_FAST;
            recharge <= 1'b1;
          end
        end
        default: begin
          // fault holds until disable or power loss
          state <= state;
        end
      endcase
    end
  end

  // charge timer, frozen during hold, kept after the cycle ends
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chg_cnt <= '0;
    end else if (state == ST_OFF) begin
      // idle: a fresh cycle starts from zero
      chg_cnt <= '0;
    end else if (state == ST_DONE && rch_qual) begin
      // a recharge cycle starts its own count
      chg_cnt <= '0;
    end else if (charging && timer_step && timer_on && !temp_fault) begin
      chg_cnt <= chg_cnt + 24'h00_0001;
    end
  end

  // end of charge filter, blanked until near float
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eoc_ms <= '0;
    end else if (state != ST_FAST || temp_fault ||
                 !s.near_float || !s.end_current_low) begin
      eoc_ms <= '0;
    end else if (ms_tick && eoc_ms <= EOC_FILTER_MS) begin
      eoc_ms <= eoc_ms + 4'h1;
    end
  end

  // end of charge latch, cleared whenever neither trickle nor fast is the state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eoc <= 1'b0;
    end else if (!charging) begin
      eoc <= 1'b0;
    end else if (eoc_ms > EOC_FILTER_MS) begin
      eoc <= 1'b1;
    end
  end

  // recharge qualification, independent of timer strap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rch_ms <= '0;
    end else if (!s.recharge_low) begin
      rch_ms <= '0;
    end else if (ms_tick && rch_ms <= RCH_FILTER_MS) begin
      rch_ms <= rch_ms + 4'h1;
    end
  end

  // steady low beyond the filter time
  assign rch_qual = (rch_ms > RCH_FILTER_MS);

  // fast serration counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serr_cnt <= '0;
    end else if (serr_cnt == SERR_CYCLES - 8'h01) begin
      serr_cnt <= '0;
    end else begin
      serr_cnt <= serr_cnt + 8'h01;
    end
  end

  // slow duty phase toggle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blink_ms <= '0;
      blink_phase <= 1'b0;
    end else if (ms_tick) begin
      if (blink_ms == BLINK_HALF_MS - 9'h001) begin
        blink_ms <= '0;
        blink_phase <= ~blink_phase;
      end else begin
        blink_ms <= blink_ms + 9'h001;
      end
    end
  end

  // high or low duty serration
  assign blink_on = serr_cnt < (blink_phase ? SERR_HI_DUTY : SERR_LO_DUTY);

  // charger enables, off in hold and lockout
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trickle_en_o <= 1'b0;
      fast_en_o <= 1'b0;
    end else begin
      trickle_en_o <= (state == ST_TRICKLE) & ~temp_fault &
        keep_ok;
      fast_en_o <= (state == ST_FAST) & ~temp_fault &
        keep_ok;
    end
  end

  // charge status pin drive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      charge_status_strong_o <= 1'b0;
      charge_status_weak_o <= 1'b0;
    end else if (!charging || !keep_ok) begin
      // done, fault, off: high impedance
      charge_status_strong_o <= 1'b0;
      charge_status_weak_o <= 1'b0;
    end else if (temp_fault && !s.end_current_low) begin
      // blink while current still high
      charge_status_strong_o <= blink_on;
      charge_status_weak_o <= 1'b0;
    end else begin
      // strong while charging, weak after end
      charge_status_strong_o <= ~eoc;
      charge_status_weak_o <= eoc;
    end
  end

  // fault pin and sense divider switch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_o <= 1'b0;
      divider_en_o <= 1'b0;
    end else begin
      fault_o <= s.short_bat | temp_fault |
        (state == ST_FAULT);
      divider_en_o <= ~sleep & ~s.enable_n;
    end
  end

  // bus request decode
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  assign bus_adr = {wb_adr_i[7:2], 2'b00};

  // timeout register with byte lanes
  // lane 3 has no storage and reads as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timeout <= TIMEOUT_RESET;
    end else if (bus_wr && bus_adr == REG_TIMEOUT) begin
      for (int i = 0; i < 3; i++) begin
        if (wb_sel_i[i]) begin
          timeout[8*i +: 8] <= wb_dat_i[8*i +: 8];
        end
      end
    end
  end

  // read mux, unmapped reads as zero
  always_comb begin
    rdata = '0;
    if (bus_adr == REG_TIMEOUT) begin
      rdata[23:0] = timeout;
    end else if (bus_adr == REG_STATUS) begin
      rdata[ST_STATE_LSB +: 3] = state;
      rdata[ST_EOC_BIT] = eoc;
      rdata[ST_TEMP_BIT] = temp_fault;
      rdata[ST_RCH_BIT] = recharge;
      rdata[ST_SHORT_BIT] = s.short_bat;
    end else if (bus_adr == REG_COUNT) begin
      rdata[23:0] = chg_cnt;
    end
  end

  // acknowledge one clock after request
  // ack drops after one cycle even with the strobe held
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rdata : '0;
    end
  end

endmodule
`default_nettype wire

// ==== lcs_sequencer_chk.sv ====
// port assertions for the charge sequencer
`default_nettype none
module lcs_sequencer_chk
  import lcs_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire lcs_sense_type sense_i, // comparator levels
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // acknowledge
  input wire logic trickle_en_o, // linear charger
  input wire logic fast_en_o, // switching charger
  input wire logic charge_status_strong_o, // strong pull-down
  input wire logic charge_status_weak_o, // weak sink
  input wire logic fault_o, // fault pin
  input wire logic divider_en_o // sense divider
);
  logic tf; // temperature fault seen at the inputs
  logic off; // both chargers idle
  assign tf = !sense_i.thermistor_off &&
    (sense_i.thermistor_hot || sense_i.thermistor_cold);
  assign off = !trickle_en_o && !fast_en_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_short; sense_i.short_bat [*6] |-> fault_o; endproperty
  a_short: assert property (p_short)
    else $error("fault pin low with shorted battery");
  property p_hold; tf [*6] |-> fault_o && off; endproperty
  a_hold: assert property (p_hold)
    else $error("charging during temperature fault");
  property p_clear;
    (!sense_i.short_bat && !tf && sense_i.enable_n) [*6] |-> !fault_o;
  endproperty
  a_clear: assert property (p_clear)
    else $error("fault pin high without cause");
  property p_lock;
    !sense_i.supply_lockout_ok [*6] |->
      off && !charge_status_strong_o && !charge_status_weak_o &&
      !divider_en_o;
  endproperty
  a_lock: assert property (p_lock)
    else $error("charger active under lockout");
  property p_rev; sense_i.vin_below_bat [*6] |-> off; endproperty
  a_rev: assert property (p_rev)
    else $error("charger active with supply under battery");
  property p_dis; sense_i.enable_n [*6] |-> off && !divider_en_o; endproperty
  a_dis: assert property (p_dis)
    else $error("charger or divider active while disabled");
  property p_pair;
    !(charge_status_strong_o && charge_status_weak_o);
  endproperty
  a_pair: assert property (p_pair)
    else $error("both status sinks on");
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack not a single pulse after request");
  property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
  a_idle: assert property (p_idle)
    else $error("read data not zero outside ack");
endmodule
bind lcs_sequencer lcs_sequencer_chk u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .sense_i(sense_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .trickle_en_o(trickle_en_o), .fast_en_o(fast_en_o),
  .charge_status_strong_o(charge_status_strong_o),
  .charge_status_weak_o(charge_status_weak_o), .fault_o(fault_o),
  .divider_en_o(divider_en_o));
`default_nettype wire

// ==== lcs_sequencer_tb_top.sv ====
// bench: drives pack conditions and the bus, checks the outputs
`default_nettype none
module lcs_sequencer_tb_top;
  import lcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] TMO = 32'h0000_00C8; // charge time in ticks
  logic clk_i = 1'b0; // clock
  logic rst_i = 1'b1; // reset
  lcs_sense_type cmd = '0; // pack condition
  lcs_sense_type sense; // model levels
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, trk, fst, stg, wk, flt, dvd; // design outputs
  int err_count = 0;
  int tests_run = 0;
  always #50 clk_i = ~clk_i;
  lcs_pack_model u_pack (.clk_i(clk_i), .cmd_i(cmd), .sense_o(sense));
  lcs_sequencer #(.MS_CYCLES(20)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .sense_i(sense), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .trickle_en_o(trk),
    .fast_en_o(fst), .charge_status_strong_o(stg),
    .charge_status_weak_o(wk), .fault_o(flt), .divider_en_o(dvd));
  // counts, verdict, end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      chk("bus ack", 32'h0000_0001, {31'h0, ack});
      give_verdict();
    end
  endtask
  // poll the state field with a bounded count
  task automatic wait_st(input logic [2:0] st);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      bus(1'b0, REG_STATUS, 32'h0000_0000, q);
      n++;
    end while (q[2:0] !== st && n < 1500);
    chk("state", {29'h0, st}, {29'h0, q[2:0]});
    if (n >= 1500)
      give_verdict();
    repeat (2) @(posedge clk_i);
  endtask
  task automatic t_regs();
    logic [31:0] q;
    bus(1'b0, REG_TIMEOUT, 32'h0000_0000, q);
    chk("timeout reset", {8'h00, TIMEOUT_RESET}, q);
    bus(1'b1, REG_TIMEOUT, 32'hFF00_0000 | TMO, q);
    bus(1'b0, REG_TIMEOUT, 32'h0000_0000, q);
    chk("timeout rw", TMO, q);
    bus(1'b1, 8'h0C, 32'hFFFF_FFFF, q);
    bus(1'b0, 8'h0C, 32'h0000_0000, q);
    chk("unmapped", 32'h0000_0000, q);
    bus(1'b1, REG_STATUS, 32'hFFFF_FFFF, q);
    bus(1'b0, REG_STATUS, 32'h0000_0000, q);
    chk("status ro", 32'h0000_0000, q);
    $display("test regs done");
  endtask
  task automatic t_trickle();
    logic [31:0] q;
    cmd.enable_n <= 1'b0;
    wait_st(3'h1);
    chk("trickle", 32'h0000_000B, {28'h0, trk, fst, stg, dvd});
    wait_st(3'h4);
    bus(1'b0, REG_COUNT, 32'h0000_0000, q);
    chk("trickle limit", (TMO >> 2) + 32'h0000_0001, q);
    chk("trickle fault", 32'h0000_0001, {30'h0, trk, flt});
    cmd.enable_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    cmd.enable_n <= 1'b0;
    wait_st(3'h1);
    cmd.trickle_low <= 1'b0;
    wait_st(3'h2);
    chk("fast", 32'h0000_0006, {28'h0, trk, fst, stg, flt});
    $display("test trickle done");
  endtask
  task automatic t_end();
    logic [31:0] q;
    cmd.end_current_low <= 1'b1;
    repeat (200) @(posedge clk_i);
    chk("blanked", 32'h0000_0002, {30'h0, stg, wk});
    cmd.near_float <= 1'b1;
    repeat (200) @(posedge clk_i);
    chk("weak sink", 32'h0000_0001, {30'h0, stg, wk});
    wait_st(3'h3);
    bus(1'b0, REG_COUNT, 32'h0000_0000, q);
    chk("full time", TMO, q);
    chk("high z", 32'h0000_0000, {30'h0, stg, wk});
    $display("test end done");
  endtask
  task automatic t_recharge();
    logic [31:0] q;
    cmd.near_float <= 1'b0;
    cmd.end_current_low <= 1'b0;
    cmd.recharge_low <= 1'b1;
    repeat (60) @(posedge clk_i);
    cmd.recharge_low <= 1'b0;
    repeat (150) @(posedge clk_i);
    bus(1'b0, REG_STATUS, 32'h0000_0000, q);
    chk("short dip", 32'h0000_0003, {29'h0, q[2:0]});
    cmd.recharge_low <= 1'b1;
    wait_st(3'h2);
    cmd.recharge_low <= 1'b0;
    bus(1'b0, REG_STATUS, 32'h0000_0000, q);
    chk("recharge flags", 32'h0000_0042, {24'h0, q[7:0]});
    chk("strong again", 32'h0000_0002, {30'h0, stg, wk});
    wait_st(3'h3);
    bus(1'b0, REG_COUNT, 32'h0000_0000, q);
    chk("half time", TMO >> 1, q);
    $display("test recharge done");
  endtask
  task automatic t_temp();
    logic [31:0] q;
    logic [31:0] c1;
    int hi;
    int lo;
    hi = 0;
    lo = 0;
    cmd.supply_lockout_ok <= 1'b0;
    wait_st(3'h0);
    chk("divider off", 32'h0000_0000, {31'h0, dvd});
    cmd.supply_lockout_ok <= 1'b1;
    wait_st(3'h2);
    repeat (40) @(posedge clk_i);
    cmd.thermistor_hot <= 1'b1;
    repeat (10) @(posedge clk_i);
    bus(1'b0, REG_COUNT, 32'h0000_0000, c1);
    repeat (400) begin
      @(posedge clk_i);
      if (stg === 1'b1)
        hi++;
      else
        lo++;
    end
    bus(1'b0, REG_COUNT, 32'h0000_0000, q);
    chk("frozen count", c1, q);
    chk("hold pins", 32'h0000_0001, {29'h0, trk, fst, flt});
    chk("blink", 32'h0000_0001, {31'h0, hi > 0 && lo > 0});
    cmd.thermistor_hot <= 1'b0;
    repeat (60) @(posedge clk_i);
    bus(1'b0, REG_COUNT, 32'h0000_0000, q);
    chk("count resumes", 32'h0000_0001, {31'h0, q > c1});
    cmd.thermistor_off <= 1'b1;
    cmd.thermistor_cold <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("monitor off", 32'h0000_0002, {30'h0, fst, flt});
    cmd.thermistor_cold <= 1'b0;
    cmd.short_bat <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("short fault", 32'h0000_0001, {31'h0, flt});
    cmd.short_bat <= 1'b0;
    $display("test temp done");
  endtask
  task automatic t_straps();
    logic [31:0] q;
    cmd.timer_tied_end_current_threshold_in <= 1'b1;
    repeat (1000) @(posedge clk_i);
    bus(1'b0, REG_STATUS, 32'h0000_0000, q);
    chk("no timeout", 32'h0000_0002, {29'h0, q[2:0]});
    cmd.timer_tied_end_current_threshold_in <= 1'b0;
    cmd.timer_grounded <= 1'b1;
    cmd.near_float <= 1'b1;
    cmd.end_current_low <= 1'b1;
    wait_st(3'h3);
    cmd.near_float <= 1'b0;
    cmd.end_current_low <= 1'b0;
    cmd.recharge_low <= 1'b1;
    wait_st(3'h2);
    cmd.recharge_low <= 1'b0;
    cmd.vin_above_bat <= 1'b0;
    cmd.vin_below_bat <= 1'b1;
    wait_st(3'h0);
    cmd.vin_below_bat <= 1'b0;
    repeat (20) @(posedge clk_i);
    bus(1'b0, REG_STATUS, 32'h0000_0000, q);
    chk("no early restart", 32'h0000_0000, {29'h0, q[2:0]});
    cmd.vin_above_bat <= 1'b1;
    wait_st(3'h2);
    $display("test straps done");
  endtask
  // reset, then the scenarios in order
  initial begin
    cmd.supply_lockout_ok = 1'b1;
    cmd.vin_above_bat = 1'b1;
    cmd.trickle_low = 1'b1;
    cmd.enable_n = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_trickle();
    t_end();
    t_recharge();
    t_temp();
    t_straps();
    give_verdict();
  end
endmodule
`default_nettype wire
